// [rtl/imm_pkg.sv]
// Purpose: shared constants for the internal data memory map
// Assumes: one 25 MHz clock, byte-wide data
// Notes:   register offsets sit on the plain register port
package imm_pkg;

  // ----------------------------------------
  // register port map
  // ----------------------------------------
  localparam logic [3:0] OFS_PSW    = 4'h0;
  localparam logic [3:0] OFS_AUX    = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;

  localparam logic [7:0] PSW_RESET  = 8'h00;
  localparam logic [7:0] AUX_RESET  = 8'h14;
  localparam logic [7:0] AUX_WMASK  = 8'h3F;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BANK_LO_POS    = 3;
  localparam int BANK_HI_POS    = 4;
  localparam int OFFCHIP_POS    = 1;
  localparam int SIZE_FIELD_LO  = 2;
  localparam int SIZE_FIELD_HI  = 4;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [7:0]  LOWER_TOP     = 8'h7F;
  localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
  localparam logic [15:0] ONCHIP_EXPANDED_RAM_TOP      = 16'h07FF;
  localparam int          IRAM_DEPTH    = 256;
  localparam int          ONCHIP_EXPANDED_RAM_DEPTH    = 2048;

  // ----------------------------------------
  // access kinds issued by the core
  // ----------------------------------------
  localparam logic [2:0] SP_DIRECT   = 3'h0;
  localparam logic [2:0] SP_INDIRECT = 3'h1;
  localparam logic [2:0] SP_BIT      = 3'h2;
  localparam logic [2:0] SP_MOVX     = 3'h3;
  localparam logic [2:0] SP_WREG     = 3'h4;

  // ----------------------------------------
  // decoded target, also shown in the status register
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    TG_NONE = 3'h0,
    TG_IRAM = 3'h1,
    TG_SFR  = 3'h2,
    TG_ONCHIP_EXPANDED_RAM = 3'h3,
    TG_EXT  = 3'h4
  } imm_target_t;

endpackage

// [rtl/imm_iram.sv]
// Purpose: 256-byte internal RAM, lower and upper segments together
// Assumes: write on the clock, read without a clock
// Notes:   contents are not cleared; they are undefined until written
`timescale 1ns/1ps
module imm_iram
#(
  parameter int DEPTH = imm_pkg::IRAM_DEPTH
)
(
  input  wire logic                     clock,  // system clock
  input  wire logic                     wrEn,   // write this cycle
  input  wire logic [$clog2(DEPTH)-1:0] addr,   // byte address
  input  wire logic [7:0]               wData,  // write data
  output logic      [7:0]               rData   // read data, same cycle
);

  logic [7:0] mem [DEPTH];

  // no reset on purpose: volatile cells
  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[addr] <= wData;
    end
  end

  assign rData = mem[addr];

endmodule

// [rtl/imm_onchip_expanded_ram.sv]
// Purpose: on-chip expanded RAM reached by external-move accesses
// Assumes: write on the clock, read without a clock
// Notes:   contents are not cleared; they are undefined until written
`timescale 1ns/1ps
module imm_onchip_expanded_ram
#(
  parameter int DEPTH = imm_pkg::ONCHIP_EXPANDED_RAM_DEPTH
)
(
  input  wire logic                     clock,  // system clock
  input  wire logic                     wrEn,   // write this cycle
  input  wire logic [$clog2(DEPTH)-1:0] addr,   // byte address
  input  wire logic [7:0]               wData,  // write data
  output logic      [7:0]               rData   // read data, same cycle
);

  logic [7:0] mem [DEPTH];

  // volatile, left uninitialised
  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      mem[addr] <= wData;
    end
  end

  assign rData = mem[addr];

endmodule

// [rtl/imm_data_map.sv]
// Purpose: steers core data accesses to internal RAM, Special_function_regs, expanded RAM or off-chip
// Assumes: core holds no request while busy is high; answers arrive as one-cycle acks
// Notes:   internal and expanded RAM answer one cycle after the request, sfr and off-chip after their ack
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module imm_data_map
(
  input  wire logic        clock,             // system clock, 25 MHz
  input  wire logic        rst_n,             // async reset, active low
  // core access port
  input  wire logic        memReq,            // access request, one cycle
  input  wire logic        memWrite,          // 1 write, 0 read
  input  wire logic [2:0]  memSpace,          // access kind
  input  wire logic [15:0] memAddr,           // byte, bit or register address
  input  wire logic [7:0]  memWData,          // write data, bit value in bit 0
  output logic      [7:0]  memRData_ff,       // read data
  output logic             memRValid_ff,      // read or write done, one cycle
  output logic             memBusy_ff,        // waiting on a far answer
  // special function register port
  output logic             sfrReq_ff,         // sfr access, one cycle
  output logic             sfrWrite_ff,       // sfr write
  output logic      [7:0]  sfrAddr_ff,        // sfr byte address
  output logic      [7:0]  sfrWData_ff,       // sfr write data
  output logic             sfrBitOp_ff,       // single-bit access
  output logic      [2:0]  sfrBitIdx_ff,      // bit inside the byte
  input  wire logic        sfrAck,            // sfr answer, one cycle
  input  wire logic [7:0]  sfrRData,          // sfr read data beside ack
  // external memory bus
  output logic             extReq_ff,         // external cycle, one cycle
  output logic             extWrite_ff,       // external write
  output logic      [15:0] extAddr_ff,        // external address
  output logic      [7:0]  extWData_ff,       // external write data
  input  wire logic        extAck,            // external answer, one cycle
  input  wire logic [7:0]  extRData,          // external read data beside ack
  // register port
  input  wire logic [3:0]  regAddr,           // register offset
  input  wire logic [7:0]  regWData,          // register write data
  input  wire logic        regWrite,          // write strobe
  input  wire logic        regRead,           // read strobe
  output logic      [7:0]  regRData_ff,       // read data, cycle after strobe
  output logic      [1:0]  bankSel_ff         // working register bank in use
);

  // ----------------------------------------
  // types and functions
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SFR  = 3'b010,
    ST_EXT  = 3'b100
  } imm_state_t;

  // usable expanded RAM top for a size code
  function automatic logic [15:0] eramTop(input logic [2:0] code);
    logic [15:0] top;
    top = imm_pkg::ONCHIP_EXPANDED_RAM_TOP;
    unique case (code)
      3'h0: top = 16'h00FF;
      3'h1: top = 16'h01FF;
      3'h2: top = 16'h02FF;
      3'h3: top = 16'h03FF;
      3'h4: top = 16'h05FF;
      3'h5, 3'h6, 3'h7: top = imm_pkg::ONCHIP_EXPANDED_RAM_TOP; // reset code is full size
    endcase
    return top;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  imm_state_t        state_ff,     nxt_state;
  logic [7:0]        psw_ff,       nxt_psw;
  logic [7:0]        aux_ff,       nxt_aux;
  imm_pkg::imm_target_t lastTg_ff, nxt_lastTg;
  logic [7:0]        memRData_nx;
  logic              memRValid_nx, memBusy_nx;
  logic              sfrReq_nx, sfrWrite_nx, sfrBitOp_nx;
  logic [7:0]        sfrAddr_nx, sfrWData_nx;
  logic [2:0]        sfrBitIdx_nx;
  logic              extReq_nx, extWrite_nx;
  logic [15:0]       extAddr_nx;
  logic [7:0]        extWData_nx, regRData_nx;

  // decode results
  imm_pkg::imm_target_t tg;
  logic [7:0]        iramAddr, iramWData, iramRData;
  logic              iramWr, isBit;
  logic [2:0]        bitIdx;
  logic [10:0]       eramAddr;
  logic [7:0]        eramRData;
  logic              eramWr;
  logic [1:0]        bank;
  logic              offchip;
  logic [15:0]       xTop;
  logic              accept;

  assign bank    = {psw_ff[imm_pkg::BANK_HI_POS], psw_ff[imm_pkg::BANK_LO_POS]};
  assign offchip = aux_ff[imm_pkg::OFFCHIP_POS];
  assign xTop    = eramTop(aux_ff[imm_pkg::SIZE_FIELD_HI:imm_pkg::SIZE_FIELD_LO]);
  assign accept  = memReq && (state_ff == ST_IDLE);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb
  begin
    tg       = imm_pkg::TG_NONE;
    iramAddr = memAddr[7:0];
    isBit    = 1'b0;
    bitIdx   = memAddr[2:0];
    eramAddr = memAddr[10:0];
    unique case (memSpace)
      imm_pkg::SP_DIRECT:
      begin
        // direct above 7Fh never reaches upper RAM
        tg = (memAddr[7:0] <= imm_pkg::LOWER_TOP) ? imm_pkg::TG_IRAM : imm_pkg::TG_SFR;
      end
      imm_pkg::SP_INDIRECT:
      begin
        // indirect covers 00h-FFh, upper half only this way
        tg = imm_pkg::TG_IRAM;
      end
      imm_pkg::SP_WREG:
      begin
        // bank picks one of four 8-byte groups at the bottom
        tg       = imm_pkg::TG_IRAM;
        iramAddr = {3'h0, bank, memAddr[2:0]};
      end
      imm_pkg::SP_BIT:
      begin
        isBit = 1'b1;
        if (memAddr[7:0] <= imm_pkg::LOWER_TOP)
        begin
          // bit n lives in byte 20h + n/8
          tg       = imm_pkg::TG_IRAM;
          iramAddr = imm_pkg::BIT_AREA_BASE + {4'h0, memAddr[6:3]};
        end
        else
        begin
          tg = imm_pkg::TG_SFR;
        end
      end
      imm_pkg::SP_MOVX:
      begin
        // on-chip only up to and including the configured top and with off-chip cleared
        if (!offchip && (memAddr <= xTop))
        begin
          tg = imm_pkg::TG_ONCHIP_EXPANDED_RAM;
        end
        else
        begin
          tg = imm_pkg::TG_EXT;
        end
      end
      default:
      begin
        tg = imm_pkg::TG_NONE;
      end
    endcase
  end

  // bit write merges into the addressed byte in the same cycle
  always_comb
  begin
    iramWData = memWData;
    if (isBit)
    begin
      iramWData         = iramRData;
      iramWData[bitIdx] = memWData[0];
    end
  end

  assign iramWr = accept && memWrite && (tg == imm_pkg::TG_IRAM);
  assign eramWr = accept && memWrite && (tg == imm_pkg::TG_ONCHIP_EXPANDED_RAM);

  imm_iram #(.DEPTH(imm_pkg::IRAM_DEPTH)) uIram
  (
    .clock (clock),
    .wrEn  (iramWr),
    .addr  (iramAddr),
    .wData (iramWData),
    .rData (iramRData)
  );

  imm_onchip_expanded_ram #(.DEPTH(imm_pkg::ONCHIP_EXPANDED_RAM_DEPTH)) uEram
  (
    .clock (clock),
    .wrEn  (eramWr),
    .addr  (eramAddr),
    .wData (memWData),
    .rData (eramRData)
  );

  // ----------------------------------------
  // access sequencing
  // ----------------------------------------
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_lastTg   = lastTg_ff;
    memRData_nx  = memRData_ff;
    memRValid_nx = 1'b0;
    memBusy_nx   = memBusy_ff;
    sfrReq_nx    = 1'b0;
    sfrWrite_nx  = sfrWrite_ff;
    sfrAddr_nx   = sfrAddr_ff;
    sfrWData_nx  = sfrWData_ff;
    sfrBitOp_nx  = sfrBitOp_ff;
    sfrBitIdx_nx = sfrBitIdx_ff;
    extReq_nx    = 1'b0;
    extWrite_nx  = extWrite_ff;
    extAddr_nx   = extAddr_ff;
    extWData_nx  = extWData_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (accept)
        begin
          nxt_lastTg = tg;
          unique case (tg)
            imm_pkg::TG_IRAM:
            begin
              memRValid_nx = 1'b1;
              memRData_nx  = isBit ? {7'h00, iramRData[bitIdx]} : iramRData;
            end
            imm_pkg::TG_ONCHIP_EXPANDED_RAM:
            begin
              memRValid_nx = 1'b1;
              memRData_nx  = eramRData;
            end
            imm_pkg::TG_SFR:
            begin
              // sfr space handed to its own port
              nxt_state    = ST_SFR;
              memBusy_nx   = 1'b1;
              sfrReq_nx    = 1'b1;
              sfrWrite_nx  = memWrite;
              sfrAddr_nx   = isBit ? {memAddr[7:3], 3'h0} : memAddr[7:0];
              sfrWData_nx  = memWData;
              sfrBitOp_nx  = isBit;
              sfrBitIdx_nx = memAddr[2:0];
            end
            imm_pkg::TG_EXT:
            begin
              nxt_state   = ST_EXT;
              memBusy_nx  = 1'b1;
              extReq_nx   = 1'b1;
              extWrite_nx = memWrite;
              extAddr_nx  = memAddr;
              extWData_nx = memWData;
            end
            default:
            begin
              // unknown kind still answers so the core never hangs
              memRValid_nx = 1'b1;
              memRData_nx  = 8'h00;
            end
          endcase
        end
      end
      ST_SFR:
      begin
        if (sfrAck)
        begin
          nxt_state    = ST_IDLE;
          memBusy_nx   = 1'b0;
          memRValid_nx = 1'b1;
          memRData_nx  = sfrRData;
        end
      end
      ST_EXT:
      begin
        if (extAck)
        begin
          nxt_state    = ST_IDLE;
          memBusy_nx   = 1'b0;
          memRValid_nx = 1'b1;
          memRData_nx  = extRData;
        end
      end
    endcase
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_comb
  begin
    nxt_psw     = psw_ff;
    nxt_aux     = aux_ff;
    regRData_nx = 8'h00;
    if (regWrite)
    begin
      unique case (regAddr)
        imm_pkg::OFS_PSW: nxt_psw = regWData;
        imm_pkg::OFS_AUX: nxt_aux = regWData & imm_pkg::AUX_WMASK;
        default:          nxt_aux = aux_ff;
      endcase
    end
    if (regRead)
    begin
      unique case (regAddr)
        imm_pkg::OFS_PSW:    regRData_nx = psw_ff;
        imm_pkg::OFS_AUX:    regRData_nx = aux_ff;
        imm_pkg::OFS_STATUS: regRData_nx = {3'h0, memBusy_ff, offchip, lastTg_ff};
        default:             regRData_nx = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff     <= ST_IDLE;
      psw_ff       <= imm_pkg::PSW_RESET;
      aux_ff       <= imm_pkg::AUX_RESET; // off-chip clear, full size
      lastTg_ff    <= imm_pkg::TG_NONE;
      memRData_ff  <= 8'h00;
      memRValid_ff <= 1'b0;
      memBusy_ff   <= 1'b0;
      sfrReq_ff    <= 1'b0;
      sfrWrite_ff  <= 1'b0;
      sfrAddr_ff   <= 8'h00;
      sfrWData_ff  <= 8'h00;
      sfrBitOp_ff  <= 1'b0;
      sfrBitIdx_ff <= 3'h0;
      extReq_ff    <= 1'b0;
      extWrite_ff  <= 1'b0;
      extAddr_ff   <= 16'h0000;
      extWData_ff  <= 8'h00;
      regRData_ff  <= 8'h00;
      bankSel_ff   <= 2'h0;
    end
    else
    begin
      state_ff     <= nxt_state;
      psw_ff       <= nxt_psw;
      aux_ff       <= nxt_aux;
      lastTg_ff    <= nxt_lastTg;
      memRData_ff  <= memRData_nx;
      memRValid_ff <= memRValid_nx;
      memBusy_ff   <= memBusy_nx;
      sfrReq_ff    <= sfrReq_nx;
      sfrWrite_ff  <= sfrWrite_nx;
      sfrAddr_ff   <= sfrAddr_nx;
      sfrWData_ff  <= sfrWData_nx;
      sfrBitOp_ff  <= sfrBitOp_nx;
      sfrBitIdx_ff <= sfrBitIdx_nx;
      extReq_ff    <= extReq_nx;
      extWrite_ff  <= extWrite_nx;
      extAddr_ff   <= extAddr_nx;
      extWData_ff  <= extWData_nx;
      regRData_ff  <= regRData_nx;
      bankSel_ff   <= {nxt_psw[imm_pkg::BANK_HI_POS], nxt_psw[imm_pkg::BANK_LO_POS]};
    end
  end

endmodule

// [tb/imm_data_map_properties.sv]
// Purpose: concurrent checks on the data memory map ports
// Assumes: one clock domain, rst_n async active low
// Notes:   shadows the aux register to know the expanded RAM size
`timescale 1ns/1ps
module imm_data_map_checker
(
  input wire logic        clock,        // system clock
  input wire logic        rst_n,        // async reset, active low
  input wire logic        memReq,       // core request
  input wire logic [2:0]  memSpace,     // access kind
  input wire logic [15:0] memAddr,      // access address
  input wire logic [7:0]  memRData_ff,  // read data
  input wire logic        memRValid_ff, // access done
  input wire logic        memBusy_ff,   // far answer pending
  input wire logic        sfrReq_ff,    // sfr cycle
  input wire logic [7:0]  sfrAddr_ff,   // sfr address
  input wire logic        sfrBitOp_ff,  // sfr single-bit access
  input wire logic [2:0]  sfrBitIdx_ff, // sfr bit index
  input wire logic        extReq_ff,    // external cycle
  input wire logic [15:0] extAddr_ff,   // external address
  input wire logic        extAck,       // external answer
  input wire logic [7:0]  extRData,     // external read data
  input wire logic [3:0]  regAddr,      // register offset
  input wire logic [7:0]  regWData,     // register write data
  input wire logic        regWrite,     // register write strobe
  input wire logic        regRead,      // register read strobe
  input wire logic [7:0]  regRData_ff,  // register read data
  input wire logic [1:0]  bankSel_ff    // bank in use
);
  logic [7:0]  auxSh_ff;
  logic [7:0]  nxt_auxSh;
  logic [15:0] sizeTop;
  logic        take;

  assign take = memReq && !memBusy_ff;

  always_comb
  begin
    nxt_auxSh = auxSh_ff;
    if (regWrite && regAddr == 4'h1)
      nxt_auxSh = regWData & imm_pkg::AUX_WMASK;
    case (auxSh_ff[4:2])
      3'h0:    sizeTop = 16'h00FF;
      3'h1:    sizeTop = 16'h01FF;
      3'h2:    sizeTop = 16'h02FF;
      3'h3:    sizeTop = 16'h03FF;
      3'h4:    sizeTop = 16'h05FF;
      default: sizeTop = 16'h07FF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      auxSh_ff <= imm_pkg::AUX_RESET;
    else
      auxSh_ff <= nxt_auxSh;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_bank_follow: assert property (regWrite && regAddr == 4'h0 |=>
    bankSel_ff == $past(regWData[4:3])) else $error("bank select did not follow");
  a_aux_readback: assert property (regRead && regAddr == 4'h1 |=>
    regRData_ff == auxSh_ff) else $error("aux read value wrong");
  a_direct_sfr: assert property (take && memSpace == imm_pkg::SP_DIRECT && memAddr[7] |=>
    sfrReq_ff && memBusy_ff && sfrAddr_ff == $past(memAddr[7:0])) else $error("no sfr cycle");
  a_bit_sfr: assert property (take && memSpace == imm_pkg::SP_BIT && memAddr[7] |=>
    sfrReq_ff && sfrBitOp_ff && sfrBitIdx_ff == $past(memAddr[2:0])
    && sfrAddr_ff == {$past(memAddr[7:3]), 3'h0}) else $error("bit sfr cycle wrong");
  a_indirect_local: assert property (take && memSpace == imm_pkg::SP_INDIRECT |=>
    memRValid_ff && !sfrReq_ff && !extReq_ff) else $error("indirect left the RAM");
  a_low_direct: assert property (take && memSpace == imm_pkg::SP_DIRECT && !memAddr[7] |=>
    memRValid_ff && !sfrReq_ff) else $error("low direct not served");
  a_bit_area: assert property (take && memSpace == imm_pkg::SP_BIT && !memAddr[7] |=>
    memRValid_ff && !sfrReq_ff) else $error("low bit not served");
  a_movx_onchip: assert property (take && memSpace == imm_pkg::SP_MOVX && !auxSh_ff[1]
    && memAddr <= sizeTop |=> memRValid_ff && !extReq_ff) else $error("move left chip");
  a_movx_external: assert property (take && memSpace == imm_pkg::SP_MOVX
    && (auxSh_ff[1] || memAddr > sizeTop) |=> extReq_ff && extAddr_ff == $past(memAddr)
    ##1 !extReq_ff) else $error("external cycle wrong");
  a_ext_answer: assert property (memBusy_ff && extAck |=>
    memRValid_ff && !memBusy_ff && memRData_ff == $past(extRData)) else $error("bad answer");

  c_offchip: cover property (take && memSpace == imm_pkg::SP_MOVX && auxSh_ff[1]);
  c_ext_ack: cover property (memBusy_ff && extAck);
  c_bank3: cover property (regWrite && regAddr == 4'h0 && regWData[4:3] == 2'h3);
endmodule

bind imm_data_map imm_data_map_checker chk_u (.clock, .rst_n, .memReq, .memSpace, .memAddr,
  .memRData_ff, .memRValid_ff, .memBusy_ff, .sfrReq_ff, .sfrAddr_ff, .sfrBitOp_ff,
  .sfrBitIdx_ff, .extReq_ff, .extAddr_ff,
  .extAck, .extRData, .regAddr, .regWData, .regWrite, .regRead, .regRData_ff, .bankSel_ff);

// [tb/imm_far_model.sv]
// Purpose: sfr block and external memory answering the map's far cycles
// Assumes: one request outstanding, answer after lat+1 idle cycles
// Notes:   read data lines toggle when not answering, like a released bus
`timescale 1ns/1ps
module imm_far_model
(
  input wire logic        clock,       // system clock
  input wire logic [2:0]  lat,         // answer delay
  input wire logic        sfrReq_ff,   // sfr cycle
  input wire logic        sfrWrite_ff, // sfr write
  input wire logic [7:0]  sfrAddr_ff,  // sfr address
  input wire logic [7:0]  sfrWData_ff, // sfr write data
  input wire logic        sfrBitOp_ff, // single-bit access
  input wire logic [2:0]  sfrBitIdx_ff,// bit inside the byte
  output logic            sfrAck,      // sfr answer
  output logic     [7:0]  sfrRData,    // sfr read data
  input wire logic        extReq_ff,   // external cycle
  input wire logic        extWrite_ff, // external write
  input wire logic [15:0] extAddr_ff,  // external address
  input wire logic [7:0]  extWData_ff, // external write data
  output logic            extAck,      // external answer
  output logic     [7:0]  extRData     // external read data
);
  logic [7:0] sfrMem [256];
  logic [7:0] extMem [65536];
  int         sCnt = -1;
  int         eCnt = -1;

  initial
  begin
    sfrAck = 1'b0;
    extAck = 1'b0;
    sfrRData = 8'h00;
    extRData = 8'h00;
  end

  always @(posedge clock)
  begin
    sfrAck <= 1'b0;
    extAck <= 1'b0;
    sfrRData <= ~sfrRData;
    extRData <= ~extRData;
    if (sfrReq_ff) sCnt <= int'(lat);
    else if (sCnt > 0) sCnt <= sCnt - 1;
    else if (sCnt == 0)
    begin
      sCnt <= -1;
      sfrAck <= 1'b1;
      if (sfrWrite_ff && sfrBitOp_ff) sfrMem[sfrAddr_ff][sfrBitIdx_ff] <= sfrWData_ff[0];
      else if (sfrWrite_ff) sfrMem[sfrAddr_ff] <= sfrWData_ff;
      else if (sfrBitOp_ff) sfrRData <= {7'h00, sfrMem[sfrAddr_ff][sfrBitIdx_ff]};
      else sfrRData <= sfrMem[sfrAddr_ff];
    end
    if (extReq_ff) eCnt <= int'(lat);
    else if (eCnt > 0) eCnt <= eCnt - 1;
    else if (eCnt == 0)
    begin
      eCnt <= -1;
      extAck <= 1'b1;
      if (extWrite_ff) extMem[extAddr_ff] <= extWData_ff;
      else extRData <= extMem[extAddr_ff];
    end
  end
endmodule

// [tb/tb_imm_data_map.sv]
// Purpose: self-checking bench for the data memory map
// Assumes: 25 MHz clock, reset held 10 cycles
// Notes:   expected data queued by drivers, compared by a monitor
`timescale 1ns/1ps
module tb_imm_data_map;
  logic clock = 1'b0, rst_n = 1'b0, memReq = 1'b0, memWrite = 1'b0;
  logic [2:0] memSpace = 3'h0, lat = 3'h0;
  logic [15:0] memAddr = 16'h0000, extAddr_ff;
  logic [7:0] memWData = 8'h00, memRData_ff, sfrAddr_ff, sfrWData_ff, sfrRData;
  logic [7:0] extWData_ff, extRData, regWData = 8'h00, regRData_ff;
  logic [3:0] regAddr = 4'h0;
  logic regWrite = 1'b0, regRead = 1'b0, regSeen = 1'b0;
  logic memRValid_ff, memBusy_ff, sfrReq_ff, sfrWrite_ff, sfrBitOp_ff, sfrAck;
  logic extReq_ff, extWrite_ff, extAck;
  logic [2:0] sfrBitIdx_ff;
  logic [1:0] bankSel_ff;
  logic [8:0] memQ [$];
  logic [7:0] regQ [$];
  logic [7:0] d;
  int miscompares = 0, numChecks = 0, b, r, j;

  imm_data_map dut_u (.clock, .rst_n, .memReq, .memWrite, .memSpace, .memAddr, .memWData,
    .memRData_ff, .memRValid_ff, .memBusy_ff, .sfrReq_ff, .sfrWrite_ff, .sfrAddr_ff,
    .sfrWData_ff, .sfrBitOp_ff, .sfrBitIdx_ff, .sfrAck, .sfrRData, .extReq_ff, .extWrite_ff,
    .extAddr_ff, .extWData_ff, .extAck, .extRData, .regAddr, .regWData, .regWrite, .regRead,
    .regRData_ff, .bankSel_ff);
  imm_far_model far_u (.clock, .lat, .sfrReq_ff, .sfrWrite_ff, .sfrAddr_ff, .sfrWData_ff,
    .sfrBitOp_ff, .sfrBitIdx_ff,
    .sfrAck, .sfrRData, .extReq_ff, .extWrite_ff, .extAddr_ff, .extWData_ff, .extAck,
    .extRData);

  initial forever #20 clock = ~clock;

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clock) regSeen <= regRead;

  // writes queue a note with bit 8 low so their done pulse is only consumed
  always @(negedge clock)
  begin
    if (memRValid_ff === 1'b1)
    begin
      if (memQ.size() == 0) chk(8'hEE, 8'h00);
      else if (memQ[0][8]) chk(memRData_ff, 8'(memQ.pop_front()));
      else void'(memQ.pop_front());
    end
    if (regSeen) chk(regRData_ff, regQ.pop_front());
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic regOp(input logic wr, input logic [3:0] a, input logic [7:0] v);
    if (!wr) regQ.push_back(v);
    @(posedge clock);
    regWrite <= wr;
    regRead <= !wr;
    regAddr <= a;
    regWData <= v;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead <= 1'b0;
  endtask

  task automatic acc(input logic [2:0] sp, input logic wr, input logic [15:0] a,
                     input logic [7:0] v);
    memQ.push_back({!wr, v});
    @(posedge clock);
    lat <= 3'($urandom_range(0, 4));
    memReq <= 1'b1;
    memSpace <= sp;
    memWrite <= wr;
    memAddr <= a;
    memWData <= v;
    @(posedge clock);
    memReq <= 1'b0;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clock);
      if (memRValid_ff === 1'b1) break;
      // a lost answer must not pass quietly
      if (n == 49)
      begin
        miscompares++;
        $display("ERROR %0t: access never answered", $time);
      end
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    complete_run();
  end

  initial
  begin
    void'($urandom(43));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    regOp(1'b0, 4'h1, 8'h14);
    regOp(1'b0, 4'h0, 8'h00);
    regOp(1'b0, 4'hF, 8'h00);
    for (b = 0; b < 4; b++)
    begin
      regOp(1'b1, 4'h0, 8'(b << 3));
      @(negedge clock);
      chk({6'h00, bankSel_ff}, 8'(b));
      r = $urandom_range(0, 7);
      d = 8'($urandom);
      acc(imm_pkg::SP_WREG, 1'b1, 16'(r), d);
      acc(imm_pkg::SP_DIRECT, 1'b0, 16'(b * 8 + r), d);
    end
    acc(imm_pkg::SP_DIRECT, 1'b1, 16'h002C, d);
    for (j = 0; j < 8; j++) acc(imm_pkg::SP_BIT, 1'b0, 16'(8'h60 + j), {7'h00, d[j]});
    acc(imm_pkg::SP_BIT, 1'b1, 16'h0061, 8'h01);
    acc(imm_pkg::SP_DIRECT, 1'b0, 16'h002C, d | 8'h02);
    acc(imm_pkg::SP_INDIRECT, 1'b0, 16'h002C, d | 8'h02);
    acc(imm_pkg::SP_INDIRECT, 1'b1, 16'h0090, 8'h3C);
    acc(imm_pkg::SP_DIRECT, 1'b1, 16'h0090, 8'hC3);
    acc(imm_pkg::SP_INDIRECT, 1'b0, 16'h0090, 8'h3C);
    acc(imm_pkg::SP_DIRECT, 1'b0, 16'h0090, 8'hC3);
    acc(imm_pkg::SP_BIT, 1'b1, 16'h0093, 8'h01);
    acc(imm_pkg::SP_BIT, 1'b0, 16'h0093, 8'h01);
    acc(imm_pkg::SP_DIRECT, 1'b0, 16'h0090, 8'hCB);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h07FF, 8'h11);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h0000, 8'h22);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h0100, 8'h55);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h0800, 8'h33);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h07FF, 8'h11);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h0800, 8'h33);
    regOp(1'b0, 4'h2, 8'h04);
    acc(3'h7, 1'b0, 16'h0000, 8'h00);
    regOp(1'b1, 4'h1, 8'h16);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h0000, 8'h44);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h0000, 8'h44);
    regOp(1'b0, 4'h2, 8'h0C);
    regOp(1'b1, 4'h1, 8'h14);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h0000, 8'h22);
    regOp(1'b1, 4'h1, 8'hC0);
    regOp(1'b0, 4'h1, 8'h00);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h0100, 8'h66);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h0100, 8'h66);
    acc(imm_pkg::SP_MOVX, 1'b1, 16'h00FF, 8'h77);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h00FF, 8'h77);
    regOp(1'b1, 4'h1, 8'h1C);
    acc(imm_pkg::SP_MOVX, 1'b0, 16'h0100, 8'h55);
    repeat (4) @(posedge clock);
    chk(8'(memQ.size() + regQ.size()), 8'h00);
    complete_run();
  end
endmodule
